// file: logic/fall_through_fifo.v
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "fall_through_fifo_defs.vh"

module fall_through_fifo #(
  parameter DATA_W = 18,
  parameter ADDR_W = 11,
  parameter OFS_W  = 12
) (
  input  wire              clk_sys,
  input  wire              srst,
  input  wire              fall_through_select,
  input  wire              offset_load_n,
  input  wire              default_offset_sel_lo,
  input  wire              default_offset_sel_hi,
  input  wire              write_enable_n,
  input  wire [DATA_W-1:0] data_in,
  input  wire              read_enable_n,
  input  wire [1:0]        reg_addr,
  input  wire [31:0]       reg_wdata,
  input  wire              reg_write,
  input  wire              reg_read,
  output reg  [31:0]       reg_rdata,
  output reg  [DATA_W-1:0] data_out,
  output reg               output_valid_n,
  output reg               input_ready_n,
  output reg               almost_empty_n,
  output reg               half_level_n,
  output reg               almost_full_n,
  output reg               fall_through_mode
);

  localparam PTR_W        = ADDR_W + 1;
  localparam MEM_DEPTH    = 1 << ADDR_W;
  localparam READY_STAGES = `FT_READY_STAGES;
  // Thresholds are compared one bit wider than pointer or offset
  localparam CMP_W        = ((OFS_W > PTR_W) ? OFS_W : PTR_W) + 1;
  localparam [PTR_W-1:0] MEM_FULL  = {1'b1, {ADDR_W{1'b0}}};
  // Half the memory plus one; fall-through mode adds one more
  localparam [PTR_W-1:0] HALF_BASE = {2'b01, {(ADDR_W-2){1'b0}}, 1'b1};
  localparam [PTR_W-1:0] ONE       = {{ADDR_W{1'b0}}, 1'b1};
  localparam [CMP_W-1:0] CMP_ONE   = {{(CMP_W-1){1'b0}}, 1'b1};

  ////////////////////////////////////////////////////////////////////////////
  // Default offset table

  function [OFS_W-1:0] defaultOffset;
    input ld;
    input selHi;
    input selLo;
    reg [19:0] v;
    begin
      // Row index is load pin, select high, select low
      case ({ld, selHi, selLo})
        3'h4:    v = `FT_OFS_1023;
        3'h2:    v = `FT_OFS_511;
        3'h1:    v = `FT_OFS_255;
        3'h0:    v = `FT_OFS_127;
        3'h3:    v = `FT_OFS_63;
        3'h6:    v = `FT_OFS_31;
        3'h5:    v = `FT_OFS_15;
        default: v = `FT_OFS_7;
      endcase
      defaultOffset = v[OFS_W-1:0];
    end
  endfunction

  // Level test shared by the three threshold flags
  function atOrAbove;
    input [CMP_W-1:0] level;
    input [CMP_W-1:0] limit;
    begin
      atOrAbove = (level >= limit);
    end
  endfunction

  // Offset registers sit at the two lowest bus addresses
  function isOffsetAddr;
    input [1:0] addr;
    begin
      isOffsetAddr = (addr == `FT_ADDR_EMPTY_OFS) ||
                     (addr == `FT_ADDR_FULL_OFS);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  reg [DATA_W-1:0] mem [0:MEM_DEPTH-1];
  reg [PTR_W-1:0]  wrPtr_ff;
  reg [PTR_W-1:0]  wrPtrSeen_ff;
  reg [PTR_W-1:0]  rdPtr_ff;
  reg              outFull_ff;
  reg [DATA_W-1:0] outWord_ff;
  reg [READY_STAGES-1:0] readyPipe_ff;
  reg [31:0]       statusNow;
  reg              serialMethod_ff;
  reg [OFS_W-1:0]  emptyOfs_ff;
  reg [OFS_W-1:0]  fullOfs_ff;
  reg              showOfs_ff;
  reg [OFS_W-1:0]  showVal_ff;

  wire [PTR_W-1:0] memCount;
  wire [PTR_W-1:0] total;
  wire [PTR_W-1:0] depthNow;
  wire             accessOk;
  wire             memFull;
  wire             visible;
  wire             wrAcc;
  wire             rdAcc;
  wire             loadOut;
  wire             nxt_outFull;

  wire [CMP_W-1:0] totalW;
  wire [CMP_W-1:0] depthW;
  wire [CMP_W-1:0] modeW;
  wire [CMP_W-1:0] nOfsW;
  wire [CMP_W-1:0] mOfsW;
  wire [CMP_W-1:0] aeLimit;
  wire [CMP_W-1:0] hlLimit;
  wire [CMP_W-1:0] afLevel;

  wire             nxt_full;
  wire             nxt_almostEmpty;
  wire             nxt_halfLevel;
  wire             nxt_almostFull;

  assign memCount = wrPtr_ff - rdPtr_ff;
  // Output register word joins the count only in fall-through mode
  assign total    = memCount + {{ADDR_W{1'b0}},
                    (fall_through_mode & outFull_ff)};
  assign depthNow = MEM_FULL + {{ADDR_W{1'b0}}, fall_through_mode};
  // Load pin low parks the write port in both modes but read requests only in fall-through mode; a standard-mode read request still empties the output register
  assign accessOk = offset_load_n;
  // Memory alone is full; the output register holds the extra word
  assign memFull  = (memCount == MEM_FULL);
  assign visible  = (wrPtrSeen_ff != rdPtr_ff);
  assign wrAcc    = !write_enable_n && accessOk && !memFull;
  // Reads need a word in the output register, so empty ignores them
  assign rdAcc    = !read_enable_n && accessOk && outFull_ff;
  assign loadOut  = fall_through_mode ?
                    (visible && (!outFull_ff || rdAcc)) :
                    (visible && !read_enable_n && accessOk);
  // Standard mode keeps the word until the next read request
  assign nxt_outFull = fall_through_mode ?
                       (loadOut || (outFull_ff && !rdAcc)) :
                       (loadOut || (outFull_ff && read_enable_n));
  // A large offset can never wrap a limit round to a small value
  assign totalW  = {{(CMP_W-PTR_W){1'b0}}, total};
  assign depthW  = {{(CMP_W-PTR_W){1'b0}}, depthNow};
  assign modeW   = {{(CMP_W-1){1'b0}}, fall_through_mode};
  assign nOfsW   = {{(CMP_W-OFS_W){1'b0}}, emptyOfs_ff};
  assign mOfsW   = {{(CMP_W-OFS_W){1'b0}}, fullOfs_ff};
  assign aeLimit = nOfsW + CMP_ONE + modeW;
  assign hlLimit = {{(CMP_W-PTR_W){1'b0}}, HALF_BASE} + modeW;
  assign afLevel = totalW + mOfsW;
  assign nxt_full        = (total == depthNow);
  assign nxt_almostEmpty = atOrAbove(totalW, aeLimit);
  assign nxt_halfLevel   = atOrAbove(totalW, hlLimit);
  assign nxt_almostFull  = atOrAbove(afLevel, depthW);

  ////////////////////////////////////////////////////////////////////////////
  // Memory write and pointers

  always @(posedge clk_sys)
  begin
    if (wrAcc)
    begin
      mem[wrPtr_ff[ADDR_W-1:0]] <= data_in;
    end
  end

  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      wrPtr_ff     <= {PTR_W{1'b0}};
      wrPtrSeen_ff <= {PTR_W{1'b0}};
    end
    else
    begin
      if (wrAcc)
      begin
        wrPtr_ff <= wrPtr_ff + ONE;
      end
      // Write pointer reaches the read side one stage late
      wrPtrSeen_ff <= wrPtr_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read pointer and output register

  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      rdPtr_ff   <= {PTR_W{1'b0}};
      outFull_ff <= 1'b0;
      outWord_ff <= {DATA_W{1'b0}};
    end
    else
    begin
      // Output register refills once empty or read in fall-through mode, only on a read request in standard mode
      if (loadOut)
      begin
        rdPtr_ff   <= rdPtr_ff + ONE;
        outWord_ff <= mem[rdPtr_ff[ADDR_W-1:0]];
      end
      outFull_ff <= nxt_outFull;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset-time configuration and offsets

  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      // Every reset edge samples again, so the last one decides
      fall_through_mode <= fall_through_select;
      serialMethod_ff   <= offset_load_n;
      emptyOfs_ff <= defaultOffset(offset_load_n, default_offset_sel_hi,
                                   default_offset_sel_lo);
      fullOfs_ff  <= defaultOffset(offset_load_n, default_offset_sel_hi,
                                   default_offset_sel_lo);
    end
    else if (reg_write && isOffsetAddr(reg_addr))
    begin
      // Software must keep values within 0 to depth minus one
      if (reg_addr == `FT_ADDR_EMPTY_OFS)
      begin
        emptyOfs_ff <= reg_wdata[OFS_W-1:0];
      end
      if (reg_addr == `FT_ADDR_FULL_OFS)
      begin
        fullOfs_ff <= reg_wdata[OFS_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags

  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      output_valid_n <= 1'b1;
      almost_empty_n <= 1'b0;
      half_level_n   <= 1'b1;
      almost_full_n  <= 1'b1;
      readyPipe_ff   <= {READY_STAGES{1'b0}};
    end
    else
    begin
      output_valid_n <= !nxt_outFull;
      // Low at n+1 or fewer, high from n+2 in fall-through mode
      almost_empty_n <= nxt_almostEmpty;
      half_level_n   <= !nxt_halfLevel;
      almost_full_n  <= !nxt_almostFull;
      // Full indication crosses a delay line before it reaches the pin
      readyPipe_ff   <= {readyPipe_ff[READY_STAGES-2:0], nxt_full};
    end
  end

  // Last stage of the delay line is the input-ready pin itself
  always @*
  begin
    input_ready_n = readyPipe_ff[READY_STAGES-1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data outputs and offset readback

  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      showOfs_ff <= 1'b0;
      showVal_ff <= {OFS_W{1'b0}};
      data_out   <= {DATA_W{1'b0}};
    end
    else
    begin
      // Offset read with load pin low shows the value on the data outputs
      showOfs_ff <= reg_read && !offset_load_n &&
                    isOffsetAddr(reg_addr);
      showVal_ff <= (reg_addr == `FT_ADDR_FULL_OFS) ? fullOfs_ff :
                    emptyOfs_ff;
      // Readback takes the outputs for one cycle, then the head returns
      if (showOfs_ff)
      begin
        data_out <= {{(DATA_W-OFS_W){1'b0}}, showVal_ff};
      end
      else if (loadOut)
      begin
        data_out <= mem[rdPtr_ff[ADDR_W-1:0]];
      end
      else
      begin
        data_out <= outWord_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word

  always @*
  begin
    statusNow                          = 32'h00000000;
    statusNow[`FT_ST_MODE]             = fall_through_mode;
    statusNow[`FT_ST_SERIAL]           = serialMethod_ff;
    statusNow[`FT_ST_IR]               = input_ready_n;
    statusNow[`FT_ST_AF]               = almost_full_n;
    statusNow[`FT_ST_HL]               = half_level_n;
    statusNow[`FT_ST_AE]               = almost_empty_n;
    statusNow[`FT_ST_OV]               = output_valid_n;
    statusNow[`FT_ST_CNT_LSB +: PTR_W] = total;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus read

  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      reg_rdata <= 32'h00000000;
    end
    else if (reg_read)
    begin
      case (reg_addr)
        `FT_ADDR_EMPTY_OFS:
          reg_rdata <= {{(32-OFS_W){1'b0}}, emptyOfs_ff};
        `FT_ADDR_FULL_OFS:
          reg_rdata <= {{(32-OFS_W){1'b0}}, fullOfs_ff};
        `FT_ADDR_STATUS:
          reg_rdata <= statusNow;
        default:
          reg_rdata <= 32'h00000000;
      endcase
    end
    else
    begin
      // Read data stand only in the cycle after the strobe
      reg_rdata <= 32'h00000000;
    end
  end

endmodule

// file: logic/fall_through_fifo_defs.vh
`ifndef FALL_THROUGH_FIFO_DEFS_VH
`define FALL_THROUGH_FIFO_DEFS_VH

// Register bus word addresses
`define FT_ADDR_EMPTY_OFS   2'h0
`define FT_ADDR_FULL_OFS    2'h1
`define FT_ADDR_STATUS      2'h2

// Status word bit positions
`define FT_ST_MODE          0
`define FT_ST_SERIAL        1
`define FT_ST_IR            2
`define FT_ST_AF            3
`define FT_ST_HL            4
`define FT_ST_AE            5
`define FT_ST_OV            6
`define FT_ST_CNT_LSB       8

// Default offsets selected at reset
`define FT_OFS_1023         20'h003FF
`define FT_OFS_511          20'h001FF
`define FT_OFS_255          20'h000FF
`define FT_OFS_127          20'h0007F
`define FT_OFS_63           20'h0003F
`define FT_OFS_31           20'h0001F
`define FT_OFS_15           20'h0000F
`define FT_OFS_7            20'h00007

// Register stages behind the flags
`define FT_VALID_STAGES     3
`define FT_READY_STAGES     2

`endif

// file: test/fall_through_fifo_assertions.sv
`timescale 1ns/1ps
module fall_through_fifo_assertions (
  input wire clk_sys,
  input wire srst,
  input wire offset_load_n,
  input wire write_enable_n,
  input wire read_enable_n,
  input wire reg_write,
  input wire output_valid_n,
  input wire input_ready_n,
  input wire almost_empty_n,
  input wire half_level_n,
  input wire fall_through_mode
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  sequence s_empty_idle;
    (output_valid_n && write_enable_n)[*3];
  endsequence
  sequence s_first_write;
    output_valid_n && !write_enable_n && offset_load_n && fall_through_mode;
  endsequence
  a_first_fall: assert property (s_empty_idle ##1 s_first_write
    |=> output_valid_n[*2] ##1 !output_valid_n) else $error("first word late");
  a_full_flags: assert property (fall_through_mode && input_ready_n
    |-> !half_level_n && !output_valid_n) else $error("full flags wrong");
  a_full_holds: assert property ((input_ready_n && read_enable_n)[*4]
    |=> input_ready_n) else $error("ready dropped without read");
  a_ready_drop: assert property ($fell(input_ready_n)
    |-> $past(!read_enable_n, 2) || $past(!read_enable_n, 3))
    else $error("ready fell without read");
  a_empty_ae: assert property (fall_through_mode && output_valid_n
    && $past(output_valid_n) |-> !almost_empty_n) else $error("ae when empty");
  a_load_blocks: assert property ((!offset_load_n)[*4]
    |-> $stable(output_valid_n) && $stable(input_ready_n))
    else $error("access while load low");
  a_mode_held: assert property (!$past(srst)
    |-> $stable(fall_through_mode)) else $error("mode changed");
  a_ae_rise: assert property ($rose(almost_empty_n)
    |-> $past(!write_enable_n, 2) || $past(reg_write) || $past(reg_write, 2))
    else $error("ae rose without cause");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind fall_through_fifo fall_through_fifo_assertions chk_u (
  .clk_sys(clk_sys), .srst(srst), .offset_load_n(offset_load_n),
  .write_enable_n(write_enable_n), .read_enable_n(read_enable_n),
  .reg_write(reg_write), .output_valid_n(output_valid_n),
  .input_ready_n(input_ready_n), .almost_empty_n(almost_empty_n),
  .half_level_n(half_level_n), .fall_through_mode(fall_through_mode));

// file: test/fifo_stream_partner.sv
`timescale 1ns/1ps
module fifo_stream_partner (
  input  wire        clk_sys,
  input  wire        wrGo,
  input  wire [17:0] wrData,
  input  wire        rdGo,
  output reg         write_enable_n = 1'b1,
  output reg  [17:0] data_in = 18'h00000,
  output reg         read_enable_n = 1'b1
);
  // Idle data lines toggle so a stray capture never looks valid
  always @(posedge clk_sys)
  begin
    write_enable_n <= ~wrGo;
    data_in        <= wrGo ? wrData : ~data_in;
    read_enable_n  <= ~rdGo;
  end
endmodule

// file: test/fall_through_fifo_flags_offsets_tb.sv
`timescale 1ns/1ps
module fall_through_fifo_flags_offsets_tb;
  localparam D = 17;
  localparam HALF = 10;
  localparam [79:0] DEFS = {10'h007, 10'h01F, 10'h00F, 10'h3FF, 10'h03F,
                            10'h1FF, 10'h0FF, 10'h07F};
  reg clkSys = 1'b0, srst = 1'b1, ftSel = 1'b1, ldN = 1'b1;
  reg selLo = 1'b0, selHi = 1'b0, wrGo = 1'b0, rdGo = 1'b0;
  reg regWrite = 1'b0, regRead = 1'b0;
  reg [17:0] wrData = 18'h00000;
  reg [1:0]  regAddr = 2'h0;
  reg [31:0] regWdata = 32'h00000000, rv;
  wire [31:0] regRdata;
  wire [17:0] dataIn, dataOut;
  wire wrEnN, rdEnN, ovN, irN, aeN, hlN, afN, ftMode;
  integer seed = 46958, fails = 0, nTests = 0, nOfs = 0, mOfs = 0, t = 0, i;
  reg [17:0] q [$];
  always #50 clkSys = ~clkSys;
  fall_through_fifo #(.ADDR_W(4), .OFS_W(10)) dut_u (
    .clk_sys(clkSys), .srst(srst), .fall_through_select(ftSel),
    .offset_load_n(ldN), .default_offset_sel_lo(selLo),
    .default_offset_sel_hi(selHi), .write_enable_n(wrEnN), .data_in(dataIn),
    .read_enable_n(rdEnN), .reg_addr(regAddr), .reg_wdata(regWdata),
    .reg_write(regWrite), .reg_read(regRead), .reg_rdata(regRdata),
    .data_out(dataOut), .output_valid_n(ovN), .input_ready_n(irN),
    .almost_empty_n(aeN), .half_level_n(hlN), .almost_full_n(afN),
    .fall_through_mode(ftMode));
  fifo_stream_partner partner_u (.clk_sys(clkSys), .wrGo(wrGo),
    .wrData(wrData), .rdGo(rdGo), .write_enable_n(wrEnN), .data_in(dataIn),
    .read_enable_n(rdEnN));
  //////////////////////////////////////////////////////////////////////////////
  function [4:0] expFlags(input integer tt);
    expFlags = {tt == D, tt < D - mOfs, tt < HALF, tt >= nOfs + 2, tt == 0};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
  begin
    nTests = nTests + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task busWr(input [1:0] a, input [31:0] d);
  begin
    @(posedge clkSys);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clkSys);
    regWrite <= 1'b0;
  end
  endtask
  task busRd(input [1:0] a);
  begin
    @(posedge clkSys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clkSys);
    regRead <= 1'b0;
    #1 rv = regRdata;
  end
  endtask
  task doReset(input [2:0] c);
  begin
    @(posedge clkSys);
    srst <= 1'b1;
    ldN <= c[2];
    selHi <= c[1];
    selLo <= c[0];
    ftSel <= (c != 3'h3);
    repeat (20) @(posedge clkSys);
    srst <= 1'b0;
    ldN <= 1'b1;
    t = 0;
    q.delete();
  end
  endtask
  task step(input w, input r);
    reg wOk;
    reg rOk;
  begin
    wOk = w && t < D;
    rOk = r && t > 0;
    rv = $random(seed);
    @(posedge clkSys);
    wrGo <= w;
    rdGo <= r;
    wrData <= rv[17:0];
    @(posedge clkSys);
    wrGo <= 1'b0;
    rdGo <= 1'b0;
    repeat (4) @(posedge clkSys);
    #1;
    if (wOk) q.push_back(rv[17:0]);
    if (rOk) void'(q.pop_front());
    t = t + wOk - rOk;
    chk({irN, afN, hlN, aeN, ovN}, expFlags(t));
    if (t > 0) chk(dataOut, q[0]);
  end
  endtask
  task wrap_up;
  begin
    $display("mismatches %0d of %0d checks", fails, nTests);
    if (fails == 0 && nTests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    for (i = 0; i < 8; i = i + 1)
    begin
      doReset(i[2:0]);
      busRd(2'h0);
      chk(rv, DEFS[i*10 +: 10]);
      busRd(2'h1);
      chk(rv, DEFS[i*10 +: 10]);
      busRd(2'h2);
      chk(rv[1:0], {i[2], i != 3});
    end
    doReset(3'h4);
    nOfs = {$random(seed)} % D;
    mOfs = {$random(seed)} % D;
    busWr(2'h0, nOfs);
    busWr(2'h1, mOfs);
    busRd(2'h1);
    chk(rv, mOfs);
    @(posedge clkSys);
    ldN <= 1'b0;
    busRd(2'h0);
    @(posedge clkSys);
    #1 rv = dataOut;
    @(posedge clkSys);
    #1 chk(rv, nOfs);
    chk(dataOut, 32'h00000000);
    @(posedge clkSys);
    ldN <= 1'b1;
    for (i = 0; i <= D; i = i + 1) step(1'b1, 1'b0);
    for (i = 0; i <= D; i = i + 1) step(1'b0, 1'b1);
    for (i = 0; i < 60; i = i + 1)
    begin
      rv = $random(seed);
      step(rv[0], rv[1]);
    end
    wrap_up;
  end
  initial
  begin
    #2000000;
    fails = fails + 1;
    wrap_up;
  end
endmodule
